// File: src/tbs_cfg.svh
`ifndef TBS_CFG_SVH
`define TBS_CFG_SVH
// Register byte offsets on the APB
`define TBS_OFF_SETUP 8'h00
`define TBS_OFF_ACTION 8'h04
`define TBS_OFF_RELOAD_LO 8'h08
`define TBS_OFF_RELOAD_HI 8'h0c
`define TBS_OFF_STAT0 8'h10
`define TBS_OFF_STAT1 8'h14
`define TBS_OFF_STAT2 8'h18
`define TBS_OFF_STAT3 8'h1c
`define TBS_OFF_SNAP_LO 8'h20
`define TBS_OFF_SNAP_HI 8'h24
`define TBS_OFF_RXW 8'h28
`define TBS_OFF_TXW 8'h2c
// Operation setup word
`define TBS_SETUP_IR 3
`define TBS_SETUP_RST 4'h0
// Action trigger word: type field and bit positions
`define TBS_ACT_CLR 4'h4
`define TBS_ACT_SET 4'h5
`define TBS_ACT_STAT 4'h6
`define TBS_ACT_LOAD 0
`define TBS_ACT_SNAP 2
`define TBS_ACT_REFRESH 6
`define TBS_ACT_CANCEL 6
`define TBS_ACT_START 7
// Event flag positions
`define TBS_EV_SUSP 8
`define TBS_EV_FIN 9
`define TBS_EV_RES 10
`define TBS_EV_START 11
`define TBS_EV_ERR 12
`define TBS_EV_CANCEL 14
`define TBS_EV_DONE 15
// Port state codes
`define TBS_CODE_RESET 4'h0
`define TBS_CODE_IDLE 4'h2
`define TBS_CODE_SH_DR 4'h4
`define TBS_CODE_SH_IR 4'h5
`define TBS_CODE_PA_DR 4'h6
`define TBS_CODE_PA_IR 4'h7
`define TBS_CODE_TRANS 4'h8
// Buffer depth and last bit index of a word
`define TBS_BUF_DEPTH 2
`define TBS_LAST_BIT 4'hf
// Default length of the input delay FIFO
`define TBS_DLY_LEN 6
`endif

// File: src/tbs_pkg.sv
package tbs_pkg;
  // Port controller states, one-hot
  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001,
    TAP_IDLE = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SH_DR = 16'h0010,
    TAP_EX1_DR = 16'h0020,
    TAP_PA_DR = 16'h0040,
    TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SH_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000,
    TAP_PA_IR = 16'h2000,
    TAP_EX2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } tbs_tap_t;
  // One serial data word
  typedef logic [15:0] tbs_word_t;
endpackage : tbs_pkg

// File: src/tbs_word_mem.sv
`timescale 1ns/100ps
`default_nettype none
module tbs_word_mem #(
  parameter int unsigned DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic push,
  input wire tbs_pkg::tbs_word_t push_data,
  input wire logic pop,
  output var tbs_pkg::tbs_word_t head,
  output logic [$clog2(DEPTH):0] used
);
  import tbs_pkg::*;
  localparam int unsigned AW = $clog2(DEPTH);
  tbs_word_t mem [DEPTH]; // Word storage, no reset needed
  logic [AW-1:0] wr_ptr; // Next slot to fill
  logic [AW-1:0] rd_ptr; // Oldest word
  logic do_push; // Push that fits
  logic do_pop; // Pop of a real word
  assign do_push = push && (used != DEPTH[AW:0]);
  assign do_pop = pop && (used != '0);
  // Storage writes; a push into a full store is dropped
  always_ff @(posedge ref_clk) begin
    if (ce && do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end
  // Pointers and fill count; depth must be a power of two
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      used <= '0;
    end else if (ce) begin
      if (do_push) wr_ptr <= wr_ptr + 1'b1;
      if (do_pop) rd_ptr <= rd_ptr + 1'b1;
      used <= used + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
  // Registered head word, one cycle behind the pointer
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      head <= '0;
    end else if (ce) begin
      head <= mem[rd_ptr];
    end
  end
endmodule : tbs_word_mem
`default_nettype wire

// File: src/tbs_scan_ctrl.sv
// What this block does
// - Event bits 8-B flag suspend/finish/resume/start
// - Bit C flags buffer overrun or underrun
// - Bit E on cancel, bit F on completion
// - External word shows event input levels
// - External bits 8-B show pending requests
// - Bit E high while active and not suspended
// - Bit F high while operation active
// - State word bits 3:0 encode port state
// - Bits 9:8 give transmit fill, never 01
// - Bits D:C give receive fill, never 10
// - Snapshot registers hold counter halves
// - 16-bit receive and transmit word registers
// - Written words shift out, input collected
// - Partial word: unused bits ignored, zero-filled
// - Delay FIFO flushed into receive buffer
// - Park only in six stable states
// - Pause when data missing or receive full
// - Final pause state skips update state
// - Action 0110 refreshes status, takes snapshot
`include "tbs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module tbs_scan_ctrl #(
  parameter int unsigned DLY_LEN = `TBS_DLY_LEN
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tck,
  input wire logic tdi,
  input wire logic [3:0] event_in,
  output logic tms,
  output logic tdo
);
  import tbs_pkg::*;

  // Transition of the port controller for one test clock edge
  function automatic tbs_tap_t next_tap(input tbs_tap_t s, input logic m);
    unique case (s)
      TAP_RESET: next_tap = m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: next_tap = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_tap = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_tap = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: next_tap = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: next_tap = m ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR: next_tap = m ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: next_tap = m ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: next_tap = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_tap = m ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: next_tap = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: next_tap = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: next_tap = m ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR: next_tap = m ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: next_tap = m ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: next_tap = m ? TAP_SEL_IR : TAP_IDLE;
      default: next_tap = TAP_RESET;
    endcase
  endfunction : next_tap

  // Mode select that walks from s toward stable goal g
  function automatic logic tms_for(input tbs_tap_t s, input tbs_tap_t g);
    logic dr;
    logic ir;
    dr = (g == TAP_SH_DR) || (g == TAP_PA_DR);
    ir = (g == TAP_SH_IR) || (g == TAP_PA_IR);
    unique case (s)
      TAP_RESET: tms_for = (g == TAP_RESET);
      TAP_IDLE, TAP_UPD_DR, TAP_UPD_IR: tms_for = (g != TAP_IDLE);
      TAP_SEL_DR: tms_for = !(dr || g == TAP_IDLE);
      TAP_CAP_DR, TAP_SH_DR, TAP_EX2_DR: tms_for = (g != TAP_SH_DR);
      TAP_EX1_DR: tms_for = !dr; // Final pause is reached without update
      TAP_PA_DR: tms_for = (g != TAP_PA_DR);
      TAP_SEL_IR: tms_for = !(ir || g == TAP_IDLE);
      TAP_CAP_IR, TAP_SH_IR, TAP_EX2_IR: tms_for = (g != TAP_SH_IR);
      TAP_EX1_IR: tms_for = !ir;
      TAP_PA_IR: tms_for = (g != TAP_PA_IR);
      default: tms_for = 1'b1;
    endcase
  endfunction : tms_for

  // Stable goal state from the final-state field
  function automatic tbs_tap_t goal_of(input logic [2:0] f);
    unique case (f)
      3'h0, 3'h1: goal_of = TAP_RESET;
      3'h2, 3'h3: goal_of = TAP_IDLE;
      3'h4: goal_of = TAP_SH_DR;
      3'h5: goal_of = TAP_SH_IR;
      3'h6: goal_of = TAP_PA_DR;
      default: goal_of = TAP_PA_IR;
    endcase
  endfunction : goal_of

  // Reported state code; all passing states share one code
  function automatic logic [3:0] tap_code(input tbs_tap_t s);
    unique case (s)
      TAP_RESET: tap_code = `TBS_CODE_RESET;
      TAP_IDLE: tap_code = `TBS_CODE_IDLE;
      TAP_SH_DR: tap_code = `TBS_CODE_SH_DR;
      TAP_SH_IR: tap_code = `TBS_CODE_SH_IR;
      TAP_PA_DR: tap_code = `TBS_CODE_PA_DR;
      TAP_PA_IR: tap_code = `TBS_CODE_PA_IR;
      default: tap_code = `TBS_CODE_TRANS;
    endcase
  endfunction : tap_code

  logic tck_s1, tck_s2, tck_s3; // Test clock synchroniser and edge history
  logic tdi_s1, tdi_s2; // Serial input synchroniser
  logic [3:0] ev_s1, ev_s2; // Event input synchronisers
  logic tck_rise, tck_fall; // Test clock edges seen on ref_clk
  logic [3:0] setup_q; // Final state and IR select
  logic [31:0] reload_q; // Counter reload value
  logic [31:0] counter_q; // Shift count counter
  logic [31:0] snap_q; // Counter snapshot
  logic [15:0] stat0_q, stat1_q, stat2_q; // Refreshed status words
  logic [15:0] ev_sticky; // Events since last refresh
  logic [15:0] ev_set; // Events this cycle
  logic [3:0] req_q; // Suspend, finish, resume, start requests
  logic active, suspended; // Operation state
  tbs_tap_t tap; // Port controller state
  tbs_tap_t shift_st, pause_st, goal; // Working and target states
  logic shift_now; // A bit shifts at the coming rising edge
  logic [3:0] bitpos; // Bit index in the transmit word
  logic [DLY_LEN-1:0] dly_d, dly_v; // Input delay FIFO data and valid
  logic flushing; // Draining the delay FIFO after the scan
  tbs_word_t rx_acc; // Receive word under assembly
  logic [3:0] rx_cnt; // Bits in rx_acc
  logic rx_push, rx_step, bit_in; // Receive path strobes
  tbs_word_t rx_word; // Word handed to the receive buffer
  tbs_word_t tx_head, rx_head; // Buffer head words
  logic [1:0] tx_used, rx_used; // Buffer fill counts
  logic tx_push, tx_pop, rx_pop, rx_full; // Buffer strobes
  logic apb_done, wr, rd; // Completing bus transfer
  logic [31:0] rd_mux; // Read data for the addressed register
  logic addr_hit; // Address is mapped
  logic act_stat, act_req, do_refresh, do_snap, do_load; // Action decode
  logic start_now, susp_now, res_now, fin_now, cancel_now, done_now;
  logic [1:0] tx_occ, rx_occ; // Occupancy codes

  assign apb_done = psel && penable && pready;
  assign wr = apb_done && pwrite;
  assign rd = apb_done && !pwrite;
  assign tck_rise = tck_s2 && !tck_s3;
  assign tck_fall = !tck_s2 && tck_s3;
  assign act_stat = wr && paddr == `TBS_OFF_ACTION && pwdata[15:12] == `TBS_ACT_STAT;
  assign act_req = wr && paddr == `TBS_OFF_ACTION
    && (pwdata[15:12] == `TBS_ACT_SET || pwdata[15:12] == `TBS_ACT_CLR);
  assign do_refresh = act_stat && pwdata[`TBS_ACT_REFRESH];
  assign do_snap = act_stat && pwdata[`TBS_ACT_SNAP];
  assign do_load = act_stat && pwdata[`TBS_ACT_LOAD];
  assign shift_st = setup_q[`TBS_SETUP_IR] ? TAP_SH_IR : TAP_SH_DR;
  assign pause_st = setup_q[`TBS_SETUP_IR] ? TAP_PA_IR : TAP_PA_DR;
  assign rx_full = rx_used == 2'(`TBS_BUF_DEPTH);
  // Stall in pause while data is missing or the receive side is full
  assign goal = !active ? goal_of(setup_q[2:0])
    : (!suspended && tx_used != 2'd0 && !rx_full) ? shift_st : pause_st;
  assign tx_occ = {tx_used != 2'd0, tx_used == 2'(`TBS_BUF_DEPTH)};
  assign rx_occ = {rx_full, rx_used != 2'd0};
  assign tx_push = wr && paddr == `TBS_OFF_TXW;
  assign rx_pop = rd && paddr == `TBS_OFF_RXW;
  assign bit_in = tck_rise && shift_now;
  assign done_now = bit_in && counter_q == 32'h0;
  // Whole words pop after bit 15; a short last word drops its unused bits
  assign tx_pop = (bit_in && (bitpos == `TBS_LAST_BIT || counter_q == 32'h0))
    || ((fin_now || cancel_now) && bitpos != 4'h0);

  // Operation events
  assign start_now = !active && !flushing
    && (req_q[3] || (act_req && pwdata[`TBS_ACT_START]));
  assign susp_now = active && !suspended && req_q[0];
  assign res_now = active && suspended && req_q[2];
  assign fin_now = active && req_q[1];
  assign cancel_now = active && act_req && pwdata[`TBS_ACT_CANCEL];

  // Event vector: set always wins over the refresh clear
  always_comb begin
    ev_set = 16'h0;
    ev_set[`TBS_EV_SUSP] = susp_now;
    ev_set[`TBS_EV_FIN] = fin_now;
    ev_set[`TBS_EV_RES] = res_now;
    ev_set[`TBS_EV_START] = start_now;
    ev_set[`TBS_EV_ERR] = (tx_push && tx_used == 2'(`TBS_BUF_DEPTH))
      || (rx_pop && rx_used == 2'd0) || (rx_push && rx_full);
    ev_set[`TBS_EV_CANCEL] = cancel_now;
    ev_set[`TBS_EV_DONE] = done_now || fin_now;
  end

  // Read decode; write-only and spare words read zero
  always_comb begin
    rd_mux = 32'h0;
    addr_hit = 1'b1;
    case (paddr)
      `TBS_OFF_SETUP: rd_mux = {28'h0, setup_q};
      `TBS_OFF_RELOAD_LO: rd_mux = {16'h0, reload_q[15:0]};
      `TBS_OFF_RELOAD_HI: rd_mux = {16'h0, reload_q[31:16]};
      `TBS_OFF_STAT0: rd_mux = {16'h0, stat0_q};
      `TBS_OFF_STAT1: rd_mux = {16'h0, stat1_q};
      `TBS_OFF_STAT2: rd_mux = {16'h0, stat2_q};
      `TBS_OFF_STAT3: rd_mux = 32'h0;
      `TBS_OFF_SNAP_LO: rd_mux = {16'h0, snap_q[15:0]};
      `TBS_OFF_SNAP_HI: rd_mux = {16'h0, snap_q[31:16]};
      `TBS_OFF_RXW: rd_mux = {16'h0, rx_head};
      `TBS_OFF_ACTION, `TBS_OFF_TXW: rd_mux = 32'h0;
      default: addr_hit = 1'b0;
    endcase
  end

  // Input synchronisers; first stages feed only second stages
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      {tck_s1, tck_s2, tck_s3, tdi_s1, tdi_s2} <= 5'h0;
      ev_s1 <= 4'h0;
      ev_s2 <= 4'h0;
    end else if (ce) begin
      {tck_s1, tck_s2, tck_s3} <= {tck, tck_s1, tck_s2};
      {tdi_s1, tdi_s2} <= {tdi, tdi_s1};
      ev_s1 <= event_in;
      ev_s2 <= ev_s1;
    end
  end

  // APB answer: one wait state, so every reply is registered
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        prdata <= pwrite ? 32'h0 : rd_mux;
        pslverr <= !addr_hit;
      end else begin
        pready <= 1'b0;
      end
    end
  end

  // Software-written setup and reload words
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      setup_q <= `TBS_SETUP_RST;
      reload_q <= 32'h0;
    end else if (ce && wr) begin
      if (paddr == `TBS_OFF_SETUP) setup_q <= pwdata[3:0];
      if (paddr == `TBS_OFF_RELOAD_LO) reload_q[15:0] <= pwdata[15:0];
      if (paddr == `TBS_OFF_RELOAD_HI) reload_q[31:16] <= pwdata[15:0];
    end
  end

  // Operation control and requests
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      active <= 1'b0;
      suspended <= 1'b0;
      req_q <= 4'h0;
    end else if (ce) begin
      if (start_now) active <= 1'b1;
      else if (cancel_now || fin_now || done_now) active <= 1'b0;
      if (start_now || res_now || !active) suspended <= 1'b0;
      else if (susp_now) suspended <= 1'b1;
      // Hardware consumes; a software set in the same cycle wins
      req_q <= (req_q & ~{start_now, res_now, fin_now, susp_now}
        & ~((act_req && pwdata[15:12] == `TBS_ACT_CLR) ? pwdata[3:0] : 4'h0))
        | ((act_req && pwdata[15:12] == `TBS_ACT_SET) ? pwdata[3:0] : 4'h0);
    end
  end

  // Status words, snapshot and sticky events
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ev_sticky <= 16'h0;
      stat0_q <= 16'h0;
      stat1_q <= 16'h0;
      stat2_q <= 16'h0;
      snap_q <= 32'h0;
    end else if (ce) begin
      ev_sticky <= do_refresh ? ev_set : (ev_sticky | ev_set);
      if (do_refresh) begin
        stat0_q <= ev_sticky | ev_set;
        stat1_q <= {active, active && !suspended, 2'b00, req_q, 4'h0, ev_s2};
        stat2_q <= {2'b00, rx_occ, 2'b00, tx_occ, 4'h0, tap_code(tap)};
      end
      if (do_snap) snap_q <= counter_q;
    end
  end

  // Port walk, serial output and bit counting
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tap <= TAP_RESET;
      tms <= 1'b1;
      tdo <= 1'b0;
      shift_now <= 1'b0;
      bitpos <= 4'h0;
      counter_q <= 32'h0;
    end else if (ce) begin
      if (do_load) counter_q <= reload_q;
      if (tck_fall) begin
        // Output changes on the falling edge, stable for the rising one
        // Leaving shift still clocks the chain, so a full receive side exits on a counted bit
        if (active && !suspended && tap == shift_st && tx_used != 2'd0) begin
          shift_now <= 1'b1;
          tdo <= tx_head[bitpos];
          tms <= counter_q == 32'h0 || rx_full
            || (bitpos == `TBS_LAST_BIT && tx_used < 2'(`TBS_BUF_DEPTH));
        end else begin
          shift_now <= 1'b0;
          tms <= tms_for(tap, goal);
        end
      end
      if (tck_rise) begin
        tap <= next_tap(tap, tms);
        shift_now <= 1'b0;
      end
      if (bit_in) begin
        counter_q <= counter_q - 32'h1;
        bitpos <= (counter_q == 32'h0) ? 4'h0 : bitpos + 4'h1;
      end else if (fin_now || cancel_now) begin
        bitpos <= 4'h0;
      end
    end
  end

  // Receive path: input bits pass the delay FIFO before assembly
  assign rx_step = bit_in || (flushing && !rx_full && dly_v != '0);
  always_comb begin
    rx_push = 1'b0;
    rx_word = rx_acc;
    if (rx_step && dly_v[0] && rx_cnt == `TBS_LAST_BIT) begin
      rx_push = 1'b1;
      rx_word[`TBS_LAST_BIT] = dly_d[0];
    end else if (flushing && dly_v == '0 && rx_cnt != 4'h0 && !rx_full) begin
      rx_push = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dly_d <= '0;
      dly_v <= '0;
      rx_acc <= 16'h0;
      rx_cnt <= 4'h0;
      flushing <= 1'b0;
    end else if (ce) begin
      if (done_now) flushing <= 1'b1;
      else if (flushing && dly_v == '0 && (rx_cnt == 4'h0 || !rx_full)) flushing <= 1'b0;
      if (rx_step) begin
        dly_d <= {bit_in && tdi_s2, dly_d[DLY_LEN-1:1]};
        dly_v <= {bit_in, dly_v[DLY_LEN-1:1]};
        if (dly_v[0]) begin
          rx_acc[rx_cnt] <= dly_d[0];
          rx_cnt <= rx_cnt + 4'h1;
        end
      end
      // Cleared words leave zeros in the bits a short word never fills
      if (rx_push) begin
        rx_acc <= 16'h0;
        rx_cnt <= 4'h0;
      end
    end
  end

  tbs_word_mem #(.DEPTH(`TBS_BUF_DEPTH)) u_tx_buf (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .push(tx_push),
    .push_data(pwdata[15:0]),
    .pop(tx_pop),
    .head(tx_head),
    .used(tx_used)
  );

  tbs_word_mem #(.DEPTH(`TBS_BUF_DEPTH)) u_rx_buf (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .push(rx_push),
    .push_data(rx_word),
    .pop(rx_pop),
    .head(rx_head),
    .used(rx_used)
  );

  // Checks beside the logic
  property p_tx_code;
    @(posedge ref_clk) disable iff (!rstn) do_refresh |=> stat2_q[9:8] != 2'b01;
  endproperty
  a_tx_code: assert property (p_tx_code) else $error("transmit code 01 reported");
  property p_rx_code;
    @(posedge ref_clk) disable iff (!rstn)
      do_refresh |=> stat2_q[13:12] != 2'b10 && stat2_q[13:12] == $past(rx_occ);
  endproperty
  a_rx_code: assert property (p_rx_code) else $error("receive code wrong");
  property p_active_bit;
    @(posedge ref_clk) disable iff (!rstn) do_refresh |=> stat1_q[15] == $past(active);
  endproperty
  a_active_bit: assert property (p_active_bit) else $error("active bit wrong");
  property p_levels;
    @(posedge ref_clk) disable iff (!rstn) do_refresh |=> stat1_q[3:0] == $past(ev_s2);
  endproperty
  a_levels: assert property (p_levels) else $error("event levels wrong");
  property p_snap;
    @(posedge ref_clk) disable iff (!rstn) do_snap && ce |=> snap_q == $past(counter_q);
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot missed");
  property p_transient;
    @(posedge ref_clk) disable iff (!rstn)
      ce && tck_rise && tap_code(tap) == `TBS_CODE_TRANS |=> tap != $past(tap);
  endproperty
  a_transient: assert property (p_transient) else $error("parked in passing state");
  property p_no_update;
    @(posedge ref_clk) disable iff (!rstn)
      ce && tck_rise && !active && tap == TAP_EX1_DR && goal == TAP_PA_DR
      |=> tap == TAP_PA_DR;
  endproperty
  a_no_update: assert property (p_no_update) else $error("update on pause end");
  property p_overrun;
    @(posedge ref_clk) disable iff (!rstn)
      ce && tx_push && tx_used == 2'(`TBS_BUF_DEPTH) |=> ev_sticky[`TBS_EV_ERR];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");
  property p_shift_data;
    @(posedge ref_clk) disable iff (!rstn) bit_in |-> tx_used != 2'd0 && !suspended;
  endproperty
  a_shift_data: assert property (p_shift_data) else $error("shift without data");
endmodule : tbs_scan_ctrl
`default_nettype wire

// File: verification/tbs_chain_model.sv
`timescale 1ns/100ps
`default_nettype none
module tbs_chain_model #(
  parameter logic [15:0] INIT = 16'hc35a
) (
  input wire logic tck,
  input wire logic tms,
  input wire logic tdo,
  output logic tdi,
  output logic [15:0] sr,
  output logic ir_seen
);
  // Next port state for tms low and high, one nibble per state
  localparam logic [63:0] NXT0 = 64'h1bddbba146644311;
  localparam logic [63:0] NXT1 = 64'h2fefcc0287855920;
  logic [3:0] st = 4'h0; // Starts in test-logic-reset
  wire logic shifting = (st == 4'h4) || (st == 4'hb); // Shift-DR or shift-IR
  initial sr = INIT;
  initial ir_seen = 1'b0;
  initial tdi = 1'b0;
  // Chain takes mode and data on the rising test clock edge
  always @(posedge tck) begin
    if (shifting) sr <= {tdo, sr[15:1]};
    if (st == 4'hb) ir_seen <= 1'b1;
    st <= tms ? NXT1[st*4 +: 4] : NXT0[st*4 +: 4];
  end
  // Data moves on the falling edge; off-shift the line carries no stale value
  always @(negedge tck) begin
    tdi <= shifting ? sr[0] : ~tdi;
  end
endmodule : tbs_chain_model
`default_nettype wire

// File: verification/test_tbs_scan_ctrl.sv
`include "tbs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module test_tbs_scan_ctrl;
  // One register access and the answer it should give
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d, x; logic e;} tbs_row_t;
  logic ref_clk = 1'b0, rstn = 1'b0, ce = 1'b1, tck = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, tdi, tms, tdo, ir_seen;
  logic [3:0] event_in = 4'ha; // Fixed levels seen in the external word
  logic [15:0] sr;
  int failures = 0, n_compared = 0, cyc = 0;
  tbs_row_t rows [18] = '{
    '{1'b1, `TBS_OFF_RELOAD_LO, 32'h5, 32'h0, 1'b0},
    '{1'b1, `TBS_OFF_RELOAD_HI, 32'h1, 32'h0, 1'b0},
    '{1'b1, `TBS_OFF_ACTION, 32'h6001, 32'h0, 1'b0},
    '{1'b1, `TBS_OFF_ACTION, 32'h6004, 32'h0, 1'b0},
    '{1'b0, `TBS_OFF_SNAP_LO, 32'h0, 32'h5, 1'b0},
    '{1'b0, `TBS_OFF_SNAP_HI, 32'h0, 32'h1, 1'b0},
    '{1'b1, `TBS_OFF_STAT3, 32'hffff, 32'h0, 1'b0},
    '{1'b1, `TBS_OFF_ACTION, 32'h6040, 32'h0, 1'b0},
    '{1'b0, `TBS_OFF_STAT0, 32'h0, 32'h0, 1'b0},
    '{1'b0, `TBS_OFF_STAT1, 32'h0, 32'ha, 1'b0},
    '{1'b0, `TBS_OFF_STAT2, 32'h0, 32'h0, 1'b0},
    '{1'b0, `TBS_OFF_STAT3, 32'h0, 32'h0, 1'b0},
    '{1'b0, `TBS_OFF_TXW, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h30, 32'h0, 32'h0, 1'b1},
    '{1'b1, `TBS_OFF_ACTION, 32'h5001, 32'h0, 1'b0},
    '{1'b1, `TBS_OFF_ACTION, 32'h6040, 32'h0, 1'b0},
    '{1'b0, `TBS_OFF_STAT1, 32'h0, 32'h10a, 1'b0},
    '{1'b1, `TBS_OFF_ACTION, 32'h4001, 32'h0, 1'b0}};
  tbs_scan_ctrl #(.DLY_LEN(2)) DUT (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tck(tck), .tdi(tdi),
    .event_in(event_in), .tms(tms), .tdo(tdo));
  tbs_chain_model chain (.tck(tck), .tms(tms), .tdo(tdo), .tdi(tdi), .sr(sr),
    .ir_seen(ir_seen));
  initial forever #5 ref_clk = ~ref_clk;
  // Test clock runs free, out of phase with the system clock
  initial begin
    #3;
    forever #80 tck = ~tck;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Refresh and read a status word until the masked value shows up
  task automatic poll(input logic [7:0] a, input logic [31:0] m, x, input string nm);
    int n;
    n = 0;
    do begin
      apb(1'b1, `TBS_OFF_ACTION, 32'h6040);
      apb(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) !== x && n < 400);
    chk(nm, rd & m, x);
  endtask : poll
  // Software scan sequence: count, load, setup, start, first word once transmit is empty
  task automatic scan(input logic [31:0] setup, cnt, tx);
    apb(1'b1, `TBS_OFF_RELOAD_LO, cnt);
    apb(1'b1, `TBS_OFF_RELOAD_HI, 32'h0);
    apb(1'b1, `TBS_OFF_ACTION, 32'h6001);
    apb(1'b1, `TBS_OFF_SETUP, setup);
    apb(1'b1, `TBS_OFF_ACTION, 32'h5080);
    poll(`TBS_OFF_STAT2, 32'h300, 32'h0, "tx empty");
    apb(1'b1, `TBS_OFF_TXW, tx);
  endtask : scan
  task automatic report_and_stop;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // Hang guard: counts as a mismatch
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      $display("[FAIL] timeout expected end seen hang");
      report_and_stop();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("row data", rd, rows[i].x);
      chk("row error", {31'h0, er}, {31'h0, rows[i].e});
    end
    // Whole DR word
    scan(32'h2, 32'd15, 32'h8b8b);
    poll(`TBS_OFF_STAT0, 32'h8000, 32'h8000, "done flag");
    poll(`TBS_OFF_STAT2, 32'hffff, 32'h1002, "idle one rx");
    apb(1'b0, `TBS_OFF_RXW, 32'h0);
    chk("rx word", rd, 32'hc35a);
    chk("chain", {16'h0, sr}, 32'h8b8b);
    // Short IR word: upper bits ignored going out, zeroed coming in
    scan(32'ha, 32'd7, 32'hffa5);
    poll(`TBS_OFF_STAT2, 32'hffff, 32'h1002, "ir done");
    apb(1'b0, `TBS_OFF_RXW, 32'h0);
    chk("short rx", rd, 32'h008b);
    chk("short chain", {16'h0, sr}, 32'ha58b);
    chk("ir path", {31'h0, ir_seen}, 32'h1);
    // Two words with the second late: port must wait in pause
    // Final state pause-DR: the run ends in pause without an update state
    scan(32'h6, 32'd31, 32'h1234);
    poll(`TBS_OFF_STAT2, 32'h30f, 32'h6, "pause dr");
    poll(`TBS_OFF_STAT1, 32'hc000, 32'hc000, "active");
    apb(1'b1, `TBS_OFF_TXW, 32'h5678);
    poll(`TBS_OFF_STAT2, 32'hffff, 32'h3006, "rx both full");
    apb(1'b0, `TBS_OFF_RXW, 32'h0);
    chk("rx first", rd, 32'ha58b);
    apb(1'b0, `TBS_OFF_RXW, 32'h0);
    chk("rx second", rd, 32'h1234);
    chk("chain two", {16'h0, sr}, 32'h5678);
    // Reading an empty receive word is a buffer failure
    apb(1'b0, `TBS_OFF_RXW, 32'h0);
    poll(`TBS_OFF_STAT0, 32'h1000, 32'h1000, "buffer failure");
    report_and_stop();
  end
endmodule : test_tbs_scan_ctrl
`default_nettype wire
